/* hw/rffc_pkg.sv */
// Package: register map, field layout and carrier types of the receive filter control
package rffc_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam logic [ADDR_W-1:0] RFC_CTL_OFS = 12'h0B0;
    localparam logic [ADDR_W-1:0] RFC_AUX_OFS = 12'h0B8;
    localparam logic [ADDR_W-1:0] RFC_CNT_OFS = 12'h0BC;

    localparam int unsigned B_KEEP_WAKE   = 15;
    localparam int unsigned B_IGMP_CHK    = 14;
    localparam int unsigned B_ICMP_CHK    = 13;
    localparam int unsigned B_TCPUDP_CHK  = 12;
    localparam int unsigned B_IP_CHK      = 11;
    localparam int unsigned B_ACC_BCAST   = 10;
    localparam int unsigned B_ACC_MCAST   = 9;
    localparam int unsigned B_ACC_UCAST   = 8;
    localparam int unsigned B_VLAN_STRIP  = 7;
    localparam int unsigned B_UNTAG_DROP  = 6;
    localparam int unsigned B_VLAN_FILT   = 5;
    localparam int unsigned B_SRC_PERFECT = 4;
    localparam int unsigned B_MC_HASH     = 3;
    localparam int unsigned B_UC_HASH     = 2;
    localparam int unsigned B_DST_PERFECT = 1;
    localparam int unsigned B_ENG_RESET   = 0;
    localparam logic [31:0] CTL_RST_VAL   = 32'h0000_0000;
    localparam logic [31:0] CTL_WR_MASK   = 32'h0000_FFFE;
    localparam int unsigned B_STORE_WAKE  = 0;
    localparam int unsigned B_DEEP_SUSP   = 1;
    localparam logic [31:0] AUX_RST_VAL   = 32'h0000_0000;

    localparam logic [15:0] RAW_CSUM_NONE = 16'h0000;
    localparam logic [2:0]  VLAN_WORD_IDX = 3'h3;
    localparam int unsigned GROUP_BIT     = 40;
    localparam int unsigned FIFO_DEPTH    = 8;
    localparam int unsigned S_IP_DONE     = 0;
    localparam int unsigned S_IP_ERR      = 1;
    localparam int unsigned S_L4_DONE     = 2;
    localparam int unsigned S_L4_ERR      = 3;
    localparam int unsigned S_WAKE_KEPT   = 4;
    localparam int unsigned S_RAW_LSB     = 16;

    typedef enum logic [1:0] {
        PROTO_OTHER, PROTO_TCPUDP, PROTO_ICMP, PROTO_IGMP
    } rffc_proto_t;

    typedef struct packed {
        logic [31:0] data;
        logic        sof;
        logic        eof;
    } rffc_word_t;

    typedef struct packed {
        logic [47:0] dst_addr;
        logic        dst_perfect_hit;
        logic        dst_hash_hit;
        logic        src_perfect_hit;
        logic        vlan_tagged;
        logic        vlan_id_hit;
        logic        is_ip;
        logic        ip_csum_ok;
        rffc_proto_t proto;
        logic        l4_csum_ok;
        logic [15:0] raw_csum;
        logic        wake_frame;
    } rffc_info_t;

    typedef struct packed {
        logic [31:0] data;
        logic        sof;
        logic        eof;
        logic        stat;
    } rffc_out_t;
endpackage

/* hw/rffc_fifo.sv */
// Synchronous valid/ready FIFO with flush
module rffc_fifo #(
    parameter int unsigned WIDTH = 35,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    wire              push = in_valid & in_ready;
    wire              pop  = out_valid & out_ready;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];

    always_ff @(posedge aclk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || flush) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            if (pop)  rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* hw/rffc_top.sv */
// Receive frame filter control: filtering, VLAN strip, checksum status, registers
// Behaviour
// - With no protocol checksum enable set, raw checksum field is 0000h.
// - Keep-wake set: deep-suspend wakeup frame with retention is never dropped.
// - Bit 14 checks IGMP checksum and reports raw checksum for all frames.
// - Bit 13 checks ICMP checksum and reports raw checksum for all frames.
// - Bit 12 checks TCP/UDP checksum and reports raw checksum for all frames.
// - Bit 11 checks IP header checksum; no effect on non-IP frames.
// - Bit 10 passes broadcast destinations; clear drops all broadcast frames except kept wakeup frames.
// - Bit 9 accepts all multicast; otherwise multicast must pass perfect or hash; a source perfect miss still drops it when a destination filter is on.
// - Accept-multicast never affects broadcast handling.
// - Bit 8 accepts every unicast frame regardless of address filtering; here a source perfect miss still drops it when a destination filter is on.
// - Bit 7 strips the VLAN tag before passing the frame on.
// - Bit 6 drops every frame without a VLAN tag, except kept wakeup frames.
// - Bit 5 filters tagged frames by their VLAN identifier.
// - Source perfect filter with destination filtering: both checks must pass.
// - Bit 3 hashes multicast destinations, never the broadcast address.
// - Bit 2 checks unicast destinations through the hash filter.
// - Writing one to bit 0 resets the engine; bit reads back zero.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
module rffc_top
    import rffc_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              in_valid,
    output logic                   in_ready,
    input  wire rffc_word_t        in_word,
    input  wire rffc_info_t        in_info,
    output logic                   out_valid,
    input  wire logic              out_ready,
    output rffc_out_t              out_word,
    input  wire logic              deep_suspend_state
);
    typedef enum logic [1:0] {ST_IDLE, ST_PASS, ST_DROP, ST_STAT} rffc_state_t;

    // Register bus state
    logic [31:0]       ctl_q;
    logic [31:0]       aux_q;
    logic              eng_rst_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic              aw_have_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              w_have_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [1:0]        rresp_q;
    logic [31:0]       rdata_q;
    logic [15:0]       acc_cnt_q;
    logic [15:0]       drop_cnt_q;
    logic              susp_q1;
    logic              susp_q2;

    // Frame path state
    rffc_state_t state_q;
    rffc_state_t state_d;
    logic [2:0]  idx_q;
    logic        tagged_q;
    logic [31:0] stat_q;

    // Write path
    wire         wr_go   = aw_have_q & w_have_q & ~bvalid_q;
    wire         wr_ctl  = wr_go & (awaddr_q == RFC_CTL_OFS);
    wire         wr_aux  = wr_go & (awaddr_q == RFC_AUX_OFS);
    wire         wr_cnt  = wr_go & (awaddr_q == RFC_CNT_OFS);
    wire         wr_ok   = wr_ctl | wr_aux | wr_cnt;
    wire [31:0]  bmask   = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire [31:0]  ctl_new = ((ctl_q & ~bmask) | (wdata_q & bmask)) & CTL_WR_MASK;
    wire [31:0]  aux_new = ((aux_q & ~bmask) | (wdata_q & bmask)) & 32'h0000_0001;
    wire         rst_req = wr_ctl & wstrb_q[0] & wdata_q[B_ENG_RESET];
    wire         eng_rst = eng_rst_q;

    assign s_axi_awready = ~aw_have_q;
    assign s_axi_wready  = ~w_have_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
        end else begin
            if (s_axi_awvalid && !aw_have_q) begin
                awaddr_q  <= s_axi_awaddr;
                aw_have_q <= 1'b1;
            end
            if (s_axi_wvalid && !w_have_q) begin
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
                w_have_q <= 1'b1;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Bit 0 is never stored, so it reads back zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_q     <= CTL_RST_VAL;
            aux_q     <= AUX_RST_VAL;
            eng_rst_q <= 1'b0;
        end else begin
            eng_rst_q <= rst_req;
            if (wr_ctl) ctl_q <= ctl_new;
            if (wr_aux) aux_q <= aux_new;
        end
    end

    // Read path
    wire [31:0] rd_cnt  = {drop_cnt_q, acc_cnt_q};
    wire [31:0] rd_aux  = {30'h0, susp_q2, aux_q[B_STORE_WAKE]};
    wire        rd_hit  = (s_axi_araddr == RFC_CTL_OFS) | (s_axi_araddr == RFC_AUX_OFS)
                        | (s_axi_araddr == RFC_CNT_OFS);
    wire [31:0] rd_mux  = (s_axi_araddr == RFC_CTL_OFS) ? ctl_q
                        : (s_axi_araddr == RFC_AUX_OFS) ? rd_aux
                        : (s_axi_araddr == RFC_CNT_OFS) ? rd_cnt : 32'h0000_0000;

    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= 2'h0;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_hit ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Suspend level is asynchronous: two flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            susp_q1 <= 1'b0;
            susp_q2 <= 1'b0;
        end else begin
            susp_q1 <= deep_suspend_state;
            susp_q2 <= susp_q1;
        end
    end

    // Frame classification and acceptance
    wire is_bcast = &in_info.dst_addr;
    wire is_mcast = ~is_bcast & in_info.dst_addr[GROUP_BIT];
    wire is_ucast = ~is_bcast & ~in_info.dst_addr[GROUP_BIT];
    wire dst_filt = ctl_q[B_DST_PERFECT] | ctl_q[B_MC_HASH] | ctl_q[B_UC_HASH];
    wire perf_ok  = ctl_q[B_DST_PERFECT] & in_info.dst_perfect_hit;
    wire mc_hash  = ctl_q[B_MC_HASH] & in_info.dst_hash_hit;
    wire uc_hash  = ctl_q[B_UC_HASH] & in_info.dst_hash_hit;
    wire bc_pass  = ctl_q[B_ACC_BCAST];
    wire mc_pass  = ctl_q[B_ACC_MCAST] | perf_ok | mc_hash;
    wire uc_pass  = ctl_q[B_ACC_UCAST] | ~dst_filt | perf_ok | uc_hash;
    wire dst_pass = (is_bcast & bc_pass) | (is_mcast & mc_pass) | (is_ucast & uc_pass);
    // Source check gates only when a destination filter is on
    wire src_pass = ~ctl_q[B_SRC_PERFECT] | ~dst_filt | in_info.src_perfect_hit;
    wire vl_drop  = ctl_q[B_UNTAG_DROP] & ~in_info.vlan_tagged;
    wire vid_drop = ctl_q[B_VLAN_FILT] & in_info.vlan_tagged & ~in_info.vlan_id_hit;
    wire wake_keep = ctl_q[B_KEEP_WAKE] & aux_q[B_STORE_WAKE] & susp_q2
                   & in_info.wake_frame;
    wire accept   = wake_keep | (dst_pass & src_pass & ~vl_drop & ~vid_drop);

    // Checksum status word
    wire csum_any = ctl_q[B_IGMP_CHK] | ctl_q[B_ICMP_CHK] | ctl_q[B_TCPUDP_CHK];
    wire [15:0] raw_sel = csum_any ? in_info.raw_csum : RAW_CSUM_NONE;
    wire ip_done  = ctl_q[B_IP_CHK] & in_info.is_ip;
    wire l4_igmp  = ctl_q[B_IGMP_CHK] & (in_info.proto == PROTO_IGMP);
    wire l4_icmp  = ctl_q[B_ICMP_CHK] & (in_info.proto == PROTO_ICMP);
    wire l4_tu    = ctl_q[B_TCPUDP_CHK] & (in_info.proto == PROTO_TCPUDP);
    wire l4_done  = l4_igmp | l4_icmp | l4_tu;
    logic [31:0] stat_new;
    always_comb begin
        stat_new = '0;
        stat_new[S_RAW_LSB +: 16] = raw_sel;
        stat_new[S_IP_DONE]   = ip_done;
        stat_new[S_IP_ERR]    = ip_done & ~in_info.ip_csum_ok;
        stat_new[S_L4_DONE]   = l4_done;
        stat_new[S_L4_ERR]    = l4_done & ~in_info.l4_csum_ok;
        stat_new[S_WAKE_KEPT] = wake_keep;
    end

    // Frame path control
    logic      fifo_in_ready;
    rffc_out_t push_word;
    wire       strip_now = (state_q == ST_PASS) & ctl_q[B_VLAN_STRIP] & tagged_q
                         & (idx_q == VLAN_WORD_IDX);
    wire       sof_beat  = (state_q == ST_IDLE) & in_valid & in_word.sof;
    wire       push_vld  = (sof_beat & accept) | ((state_q == ST_PASS) & in_valid & ~strip_now)
                         | (state_q == ST_STAT);
    wire       in_fire   = in_valid & in_ready;

    assign in_ready = (state_q == ST_DROP) | (((state_q == ST_IDLE) | (state_q == ST_PASS))
                    & fifo_in_ready);
    assign push_word = (state_q == ST_STAT) ? '{data: stat_q, sof: 1'b0, eof: 1'b0, stat: 1'b1}
                     : '{data: in_word.data, sof: in_word.sof, eof: in_word.eof, stat: 1'b0};

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: if (in_fire && in_word.sof) begin
                if (accept) state_d = in_word.eof ? ST_STAT : ST_PASS;
                else        state_d = in_word.eof ? ST_IDLE : ST_DROP;
            end
            ST_PASS: if (in_fire && in_word.eof) state_d = ST_STAT;
            ST_DROP: if (in_fire && in_word.eof) state_d = ST_IDLE;
            ST_STAT: if (fifo_in_ready) state_d = ST_IDLE;
        endcase
    end

    // Engine reset drops any frame in flight and flushes the FIFO
    always_ff @(posedge aclk) begin
        if (!aresetn || eng_rst) begin
            state_q  <= ST_IDLE;
            idx_q    <= '0;
            tagged_q <= 1'b0;
            stat_q   <= '0;
        end else begin
            state_q <= state_d;
            if (in_fire && sof_beat) begin
                idx_q    <= 3'h1;
                tagged_q <= in_info.vlan_tagged;
                stat_q   <= stat_new;
            end else if (in_fire && state_q == ST_PASS && idx_q != 3'h7) begin
                idx_q <= idx_q + 3'h1;
            end
        end
    end

    // Frame counters wrap; software reads both halves in one access
    always_ff @(posedge aclk) begin
        if (!aresetn || eng_rst || wr_cnt) begin
            acc_cnt_q  <= '0;
            drop_cnt_q <= '0;
        end else if (in_fire && sof_beat) begin
            if (accept) acc_cnt_q  <= acc_cnt_q + 16'h0001;
            else        drop_cnt_q <= drop_cnt_q + 16'h0001;
        end
    end

    rffc_fifo #(
        .WIDTH ($bits(rffc_out_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .flush     (eng_rst),
        .in_valid  (push_vld),
        .in_ready  (fifo_in_ready),
        .in_data   (push_word),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_word)
    );
endmodule

/* tb/rffc_top_asserts.sv */
// Port-level checker of the receive filter control
module rffc_top_asserts
    import rffc_pkg::*;
(
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic              out_valid,
    input wire logic              out_ready,
    input wire rffc_out_t         out_word
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic want_stat_q;
    wire  pop    = out_valid && out_ready;
    wire  mapped = s_axi_araddr == RFC_CTL_OFS || s_axi_araddr == RFC_AUX_OFS ||
                   s_axi_araddr == RFC_CNT_OFS;
    // Last data word of a frame owes a status word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            want_stat_q <= 1'b0;
        end else if (pop) begin
            want_stat_q <= out_word.eof && !out_word.stat;
        end
    end

    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_write_answer: assert property (wr_taken |=> ##[0:1] s_axi_bvalid)
        else $error("write response missing");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read response dropped early");
    a_ar_gate: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while response pending");
    a_unmapped_read: assert property (rd_taken ##0 !mapped |=>
        s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_ctl_format: assert property (rd_taken ##0 s_axi_araddr == RFC_CTL_OFS |=>
        s_axi_rvalid && s_axi_rdata[31:16] == 16'h0 && !s_axi_rdata[0])
        else $error("control register read format wrong");
    a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
        else $error("output word changed while stalled");
    a_stat_follows: assert property (pop && want_stat_q |-> out_word.stat)
        else $error("status word missing after frame");
endmodule

bind rffc_top rffc_top_asserts rffc_top_asserts_i (.*);

/* tb/rffc_mac_model.sv */
// Receive MAC source and FIFO controller sink model
module rffc_mac_model
    import rffc_pkg::*;
(
    input  wire logic      aclk,
    input  wire logic      in_ready,
    input  wire logic      out_valid,
    input  wire rffc_out_t out_word,
    output logic           in_valid,
    output rffc_word_t     in_word,
    output rffc_info_t     in_info,
    output logic           out_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic      stall = 1'b0;
    rffc_out_t got[$];

    initial {in_valid, in_word, in_info} = '0;
    assign out_ready = !stall;
    always @(negedge aclk) begin
        if (out_valid && out_ready) begin
            got.push_back(out_word);
        end
    end

    task automatic send(input rffc_info_t inf, input int nb, input logic [31:0] base);
        int   n;
        logic acc;
        @(posedge aclk);
        in_info <= inf;
        for (int i = 0; i < nb; i++) begin
            in_valid     <= 1'b1;
            in_word.data <= base + i;
            in_word.sof  <= (i == 0);
            in_word.eof  <= (i == nb - 1);
            n = 0;
            do begin
                @(negedge aclk);
                acc = in_ready;
                @(posedge aclk);
                n++;
            end while (!acc && n < 500);
            // Scramble sideband past sof: design must not read it
            if (i == 0) in_info <= ~inf;
        end
        in_valid     <= 1'b0;
        in_word.data <= ~(base + nb - 1);
    endtask
endmodule

/* tb/rffc_top_tb.sv */
// Self-checking bench: register access and frame filtering scenarios
module rffc_top_tb
    import rffc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] RAW = 16'hA5C3;
    // {control, class, dph dhh sph tag vid ip ipok proto l4ok wake, accept}
    localparam logic [29:0] TBL [17] = '{
        {16'h0C08, 2'd0, 11'h000, 1'b1},
        {16'h0200, 2'd0, 11'h000, 1'b0},
        {16'h4200, 2'd1, 11'h000, 1'b1},
        {16'h0008, 2'd1, 11'h000, 1'b0},
        {16'h2008, 2'd1, 11'h200, 1'b1},
        {16'h1102, 2'd2, 11'h004, 1'b1},
        {16'h0004, 2'd2, 11'h200, 1'b1},
        {16'h0004, 2'd2, 11'h000, 1'b0},
        {16'h0012, 2'd2, 11'h400, 1'b0},
        {16'h0012, 2'd2, 11'h500, 1'b1},
        {16'h0440, 2'd0, 11'h000, 1'b0},
        {16'h0440, 2'd0, 11'h080, 1'b1},
        {16'h0420, 2'd0, 11'h080, 1'b0},
        {16'h0420, 2'd0, 11'h0C0, 1'b1},
        {16'h0C80, 2'd0, 11'h0A0, 1'b1},
        {16'h8000, 2'd0, 11'h001, 1'b1},
        {16'h0000, 2'd0, 11'h001, 1'b0}
    };
    logic              aclk = 1'b0;
    logic              aresetn = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic [31:0]       wdata = '0;
    logic              awvalid = 1'b0;
    logic              wvalid = 1'b0;
    logic              bready = 1'b0;
    logic              arvalid = 1'b0;
    logic              rready = 1'b0;
    logic              deep = 1'b0;
    logic              awready, wready, bvalid, arready, rvalid, in_valid, in_ready;
    logic              out_valid, out_ready;
    logic [1:0]        bresp, rresp;
    logic [31:0]       rdata;
    rffc_word_t        in_word;
    rffc_info_t        in_info;
    rffc_out_t         out_word;
    int                num_errors = 0;
    int                checks = 0;
    int                n_acc = 0, n_drop = 0;

    initial forever #2 aclk = ~aclk;

    rffc_top rffc_top_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .in_valid(in_valid), .in_ready(in_ready), .in_word(in_word), .in_info(in_info),
        .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word),
        .deep_suspend_state(deep)
    );
    rffc_mac_model rffc_mac_model_i (
        .aclk(aclk), .in_ready(in_ready), .out_valid(out_valid), .out_word(out_word),
        .in_valid(in_valid), .in_word(in_word), .in_info(in_info), .out_ready(out_ready)
    );

    task automatic summarize();
        if (num_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        cmp_word({30'h0, got}, {30'h0, exp});
    endtask
    task automatic tick_limit(inout int n);
        n++;
        if (n > 200) begin
            num_errors++;
            summarize();
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
        int   n = 0;
        logic aw_hs, w_hs, b_hs = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!b_hs) begin
            @(negedge aclk);
            aw_hs = awvalid && awready;
            w_hs  = wvalid && wready;
            b_hs  = bvalid && bready;
            if (b_hs) cmp_resp(bresp, er);
            @(posedge aclk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
            tick_limit(n);
        end
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
        int   n = 0;
        logic ar_hs, r_hs = 1'b0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!r_hs) begin
            @(negedge aclk);
            ar_hs = arvalid && arready;
            r_hs  = rvalid && rready;
            if (r_hs) cmp_word(rdata, ed);
            if (r_hs) cmp_resp(rresp, er);
            @(posedge aclk);
            if (ar_hs) arvalid <= 1'b0;
            tick_limit(n);
        end
        rready <= 1'b0;
    endtask
    task automatic frame(input logic [29:0] row, input int nb, input logic stall);
        rffc_info_t  inf;
        logic [15:0] ctl;
        logic [31:0] base, st;
        int          nexp, k, j, n;
        logic        acc, strip;
        ctl = row[29:14];
        acc = row[0];
        inf = {row[13:12] == 2'd0 ? 48'hFFFF_FFFF_FFFF :
               row[13:12] == 2'd1 ? 48'h0100_5E00_0001 : 48'h0200_0000_0001,
               row[11:2], RAW, row[1]};
        st = '0;
        st[31:16] = |ctl[14:12] ? RAW : RAW_CSUM_NONE;
        st[0] = ctl[11] && inf.is_ip;
        st[1] = st[0] && !inf.ip_csum_ok;
        st[2] = (inf.proto == PROTO_TCPUDP && ctl[12]) || (inf.proto == PROTO_ICMP && ctl[13])
                || (inf.proto == PROTO_IGMP && ctl[14]);
        st[3] = st[2] && !inf.l4_csum_ok;
        st[4] = ctl[15] && inf.wake_frame;
        strip = ctl[7] && inf.vlan_tagged;
        nexp = acc ? nb + 1 - strip : 0;
        base = {row[29:10], 12'h000};
        wr(RFC_CTL_OFS, {16'h0, ctl}, 2'h0);
        rffc_mac_model_i.got.delete();
        rffc_mac_model_i.stall <= stall;
        fork
            rffc_mac_model_i.send(inf, nb, base);
            if (stall) begin
                n = 0;
                do begin
                    @(negedge aclk);
                    n++;
                end while (in_ready && n < 200);
                cmp_word({31'h0, in_ready}, 32'h0);
                cmp_word({31'h0, out_valid}, 32'h1);
                @(posedge aclk);
                rffc_mac_model_i.stall <= 1'b0;
            end
        join
        n = 0;
        while (n < 40 && !(nexp > 0 && rffc_mac_model_i.got.size() == nexp)) begin
            @(posedge aclk);
            n++;
        end
        cmp_word(rffc_mac_model_i.got.size(), nexp);
        k = 0;
        for (j = 0; j < nb && acc; j++) begin
            if (!(strip && j == 3)) begin
                cmp_word(rffc_mac_model_i.got[k].data, base + j);
                cmp_word({29'h0, rffc_mac_model_i.got[k][2:0]}, {29'h0, j == 0, j == nb - 1, 1'b0});
                k++;
            end
        end
        if (acc) begin
            cmp_word(rffc_mac_model_i.got[k].data, st);
            cmp_word({31'h0, rffc_mac_model_i.got[k].stat}, 32'h1);
            n_acc++;
        end else begin
            n_drop++;
        end
    endtask

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(RFC_CTL_OFS, CTL_RST_VAL, 2'h0);
        rd(RFC_AUX_OFS, AUX_RST_VAL, 2'h0);
        rd(RFC_CNT_OFS, 32'h0, 2'h0);
        wr(RFC_CTL_OFS, 32'hFFFF_FFFF, 2'h0);
        rd(RFC_CTL_OFS, 32'h0000_FFFE, 2'h0);
        rd(12'h0B4, 32'h0, 2'h2);
        wr(12'h0C0, 32'h1, 2'h2);
        for (int i = 0; i < 15; i++) frame(TBL[i], 6, 1'b0);
        frame({16'h0400, 2'd0, 11'h000, 1'b1}, 14, 1'b1);
        deep <= 1'b1;
        wr(RFC_AUX_OFS, 32'h1, 2'h0);
        rd(RFC_AUX_OFS, 32'h3, 2'h0);
        for (int i = 15; i < 17; i++) frame(TBL[i], 6, 1'b0);
        rd(RFC_CNT_OFS, {n_drop[15:0], n_acc[15:0]}, 2'h0);
        wr(RFC_CNT_OFS, 32'h0, 2'h0);
        rd(RFC_CNT_OFS, 32'h0, 2'h0);
        summarize();
    end
endmodule
